// ### inc/hp_amp_pkg.sv
// package: register map, field positions and gain decode constants
package hp_amp_pkg;
    localparam logic [11:0] mode_reg_addr = 12'h000;
    localparam logic [11:0] volume_reg_addr = 12'h004;
    localparam logic [11:0] status_reg_addr = 12'h008;

    // mode register fields
    localparam int mute_right_bit = 0;
    localparam int right_off_bit = 1;
    localparam int mute_left_bit = 2;
    localparam int neg_rail_only_bit = 4;
    localparam int bias_ref_bit = 5;
    localparam int left_off_bit = 6;
    localparam logic [6:0] mode_write_mask = 7'h77;

    // volume register fields
    localparam int gain_code_msb = 5;
    localparam int power_down_bit = 6;

    // status register fields
    localparam int st_left_on_bit = 0;
    localparam int st_right_on_bit = 1;
    localparam int st_pump_on_bit = 2;
    localparam int st_bias_on_bit = 3;
    localparam int st_mono_bit = 4;
    localparam int st_left_mute_bit = 5;
    localparam int st_right_mute_bit = 6;
    localparam int st_gain_lsb = 8;
    localparam int st_gain_msb = 16;

    localparam logic [6:0] mode_reset = 7'h00;
    localparam logic [6:0] volume_reset = 7'h00;

    // gain in half-dB units, signed; nine bits since -96 dB is -192 half steps
    localparam logic [5:0] code_upper_base = 6'h1f;
    localparam logic signed [8:0] gain_upper_base = 9'sh1e8;  // -12 dB
    localparam logic signed [8:0] gain_code0 = 9'sh140;       // -96 dB
endpackage

// ### rtl/gain_decode.sv
// gain code to half-dB gain step lookup
`timescale 1ns/1ps
`default_nettype none
module gain_decode
    import hp_amp_pkg::*;
(
    input wire logic [5:0] code,
    output logic signed [8:0] gain_half_db
);
    always_comb
    begin
        gain_half_db = gain_code0;
        if (code >= code_upper_base)
        begin
            gain_half_db = gain_upper_base + 9'(code - code_upper_base);  // [RL1]
        end
        else
        begin
            case (code)  // [RL12]
                6'h00: gain_half_db = gain_code0;
                6'h01: gain_half_db = -9'sd120;
                6'h02: gain_half_db = -9'sd114;
                6'h03: gain_half_db = -9'sd108;
                6'h04: gain_half_db = -9'sd102;
                6'h05: gain_half_db = -9'sd96;
                6'h06: gain_half_db = -9'sd90;
                6'h07: gain_half_db = -9'sd84;
                6'h08: gain_half_db = -9'sd78;
                6'h09: gain_half_db = -9'sd72;
                6'h0a: gain_half_db = -9'sd69;
                6'h0b: gain_half_db = -9'sd66;
                6'h0c: gain_half_db = -9'sd63;
                6'h0d: gain_half_db = -9'sd60;
                6'h0e: gain_half_db = -9'sd57;
                6'h0f: gain_half_db = -9'sd54;
                6'h10: gain_half_db = -9'sd51;
                6'h11: gain_half_db = -9'sd48;
                6'h12: gain_half_db = -9'sd45;
                6'h13: gain_half_db = -9'sd42;
                6'h14: gain_half_db = -9'sd39;
                6'h15: gain_half_db = -9'sd36;
                6'h16: gain_half_db = -9'sd33;
                6'h17: gain_half_db = -9'sd32;
                6'h18: gain_half_db = -9'sd31;
                6'h19: gain_half_db = -9'sd30;
                6'h1a: gain_half_db = -9'sd29;
                6'h1b: gain_half_db = -9'sd28;
                6'h1c: gain_half_db = -9'sd27;
                6'h1d: gain_half_db = -9'sd26;
                6'h1e: gain_half_db = -9'sd25;
                default: gain_half_db = gain_code0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### rtl/headphone_amp_control.sv
// headphone amplifier control block with apb register slave
//
// Summary of operation
// RL1 - upper gain codes step 0.5 dB from -12 dB at 011111 to 4 dB.
// RL2 - mode bit 6 turns left channel off, bit 1 turns right off.
// RL3 - right off only: right disabled, both inputs summed onto left output.
// RL4 - left off only: left disabled, right input alone on right output.
// RL5 - both channel off bits set: both channels off, charge pump runs.
// RL6 - volume bit 6 powers down both amplifiers and charge pump.
// RL7 - global power-down overrides every other shutdown control.
// RL8 - mode bit 2 mutes left, bit 0 mutes right.
// RL9 - mode bit 5 high enables the bias reference, low disables it.
// RL10 - host clears mode bit 5 to let amplifiers track the supply.
// RL11 - mode bit 4 disables both channels, charge pump stays active.
// RL12 - code 000000 gives -96 dB, 000001 gives -60 dB, lower table follows.
// RL13 - one gain code drives both channels; mute or shutdown keeps it.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module headphone_amp_control
    import hp_amp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic left_amp_en,
    output logic right_amp_en,
    output logic charge_pump_en,
    output logic bias_ref_en,
    output logic mono_sum_en,
    output logic left_mute,
    output logic right_mute,
    output logic signed [8:0] gain_half_db
);
    import hp_amp_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [6:0] mode_r;
    logic [6:0] volume_r;
    logic signed [8:0] gain_dec;
    logic wr_en;
    logic rd_en;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_r <= mode_reset;
        else if (wr_en && paddr == mode_reg_addr)
            mode_r <= pwdata[6:0] & mode_write_mask;  // [RL2] [RL8] [RL9] [RL11]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            volume_r <= volume_reset;
        else if (wr_en && paddr == volume_reg_addr)
            volume_r <= pwdata[6:0];  // [RL6]
    end

    // ----------------------------------------
    // power and routing decode
    // ----------------------------------------
    logic pd;
    logic rail_only;
    logic l_off;
    logic r_off;
    logic l_on_nxt;
    logic r_on_nxt;
    logic mono_nxt;
    logic pump_nxt;
    logic bias_nxt;

    assign pd = volume_r[power_down_bit];
    assign rail_only = mode_r[neg_rail_only_bit];
    assign l_off = mode_r[left_off_bit];
    assign r_off = mode_r[right_off_bit];

    // power-down gates every enable path so it wins over all other shutdown bits  [RL7]
    assign l_on_nxt = !pd && !rail_only && !l_off;  // [RL2] [RL3] [RL5] [RL11]
    assign r_on_nxt = !pd && !rail_only && !r_off;  // [RL2] [RL4] [RL5] [RL11]
    assign mono_nxt = l_on_nxt && r_off;  // [RL3] [RL4]
    assign pump_nxt = !pd;  // [RL5] [RL6] [RL11]
    // bias follows mode bit 5 in pump-only mode too; only power-down forces it off
    assign bias_nxt = !pd && mode_r[bias_ref_bit];  // [RL9]

    gain_decode u_gain
    (
        .code(volume_r[gain_code_msb:0]),
        .gain_half_db(gain_dec)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            left_amp_en <= 1'b0;
            right_amp_en <= 1'b0;
            mono_sum_en <= 1'b0;
            charge_pump_en <= 1'b0;
            bias_ref_en <= 1'b0;
        end
        else
        begin
            left_amp_en <= l_on_nxt;
            right_amp_en <= r_on_nxt;
            mono_sum_en <= mono_nxt;
            charge_pump_en <= pump_nxt;
            bias_ref_en <= bias_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            left_mute <= 1'b0;
            right_mute <= 1'b0;
        end
        else
        begin
            left_mute <= mode_r[mute_left_bit];  // [RL8]
            right_mute <= mode_r[mute_right_bit];  // [RL8]
        end
    end

    // one code feeds both channels; mute and shutdown never touch it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gain_half_db <= gain_code0;
        else
            gain_half_db <= gain_dec;  // [RL13] [RL1] [RL12]
    end

    // ----------------------------------------
    // apb answer
    // ----------------------------------------
    function automatic logic [31:0] read_mux(input logic [11:0] a);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            mode_reg_addr: v[6:0] = mode_r;
            volume_reg_addr: v[6:0] = volume_r;
            status_reg_addr:
            begin
                v[st_left_on_bit] = left_amp_en;
                v[st_right_on_bit] = right_amp_en;
                v[st_pump_on_bit] = charge_pump_en;
                v[st_bias_on_bit] = bias_ref_en;
                v[st_mono_bit] = mono_sum_en;
                v[st_left_mute_bit] = left_mute;
                v[st_right_mute_bit] = right_mute;
                v[st_gain_msb:st_gain_lsb] = gain_half_db;
            end
            default: v = 32'h0;
        endcase
        return v;
    endfunction

    function automatic logic addr_ok(input logic [11:0] a, input logic w);
        return a == mode_reg_addr || a == volume_reg_addr || (a == status_reg_addr && !w);
    endfunction

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
            prdata <= read_mux(paddr);
    end

    // no wait state: pready rises in the first access cycle, done at the next edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok(paddr, pwrite);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_pd_override: assert property (@(posedge pclk) disable iff (!presetn) // [RL7]
        volume_r[power_down_bit] |=> !left_amp_en && !right_amp_en && !charge_pump_en)
        else $error("power-down did not disable the device");
    chk_rail_only: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
        (mode_r[neg_rail_only_bit] && !volume_r[power_down_bit])
        |=> !left_amp_en && !right_amp_en && charge_pump_en)
        else $error("pump-only mode wrong");
    chk_mono_route: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
        (r_off && !l_off && !pd && !rail_only) |=> mono_sum_en && left_amp_en && !right_amp_en)
        else $error("mono summing not applied");
    chk_left_off: assert property (@(posedge pclk) disable iff (!presetn) // [RL4]
        (l_off && !r_off && !pd && !rail_only) |=> !mono_sum_en && !left_amp_en && right_amp_en)
        else $error("left shutdown route wrong");
    chk_both_off: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
        (l_off && r_off && !pd) |=> !left_amp_en && !right_amp_en && charge_pump_en)
        else $error("both-off pump state wrong");
    chk_mute_map: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
        ##1 left_mute == $past(mode_r[mute_left_bit]) && right_mute == $past(mode_r[mute_right_bit]))
        else $error("mute does not follow mode bits");
    chk_bias_map: assert property (@(posedge pclk) disable iff (!presetn) // [RL9]
        (!pd && $changed(mode_r[bias_ref_bit])) |=> bias_ref_en == $past(mode_r[bias_ref_bit]))
        else $error("bias enable mismatch");
    chk_gain_top: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
        (volume_r[gain_code_msb:0] == 6'h37) |=> gain_half_db == 9'sh000)
        else $error("code 110111 not 0 dB");
    chk_gain_low: assert property (@(posedge pclk) disable iff (!presetn) // [RL12]
        (volume_r[gain_code_msb:0] == 6'h01) |=> gain_half_db == -9'sd120)
        else $error("code 000001 not -60 dB");
    chk_gain_kept: assert property (@(posedge pclk) disable iff (!presetn) // [RL13]
        ($stable(volume_r) && $changed(mode_r)) |=> ##1 $stable(gain_half_db))
        else $error("gain moved on mute or shutdown");
    chk_mode_write: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
        (wr_en && paddr == mode_reg_addr) |=> mode_r == ($past(pwdata[6:0]) & mode_write_mask))
        else $error("mode write lost");
endmodule
`default_nettype wire

// ### tb/apb_host_model.sv
// apb host model that writes and reads the control block's registers
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end

    // ------------------------------------------------------------
    // one transfer
    // ------------------------------------------------------------
    // enter just after a rising edge; an idle edge at the end keeps calls from colliding
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
        output logic [31:0] rdata, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        // no fixed latency assumed: the bench timeout ends a hang
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the headphone amplifier control block
`timescale 1ns/1ps
`default_nettype none
`define chk(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
    import hp_amp_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic left_amp_en, right_amp_en, charge_pump_en, bias_ref_en, mono_sum_en;
    logic left_mute, right_mute;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic signed [8:0] gain_half_db;
    int err_total = 0, samples_checked = 0, cycles = 0, seed = 95, mode_m, vol_m;
    int lo_tab[31] = '{-192, -120, -114, -108, -102, -96, -90, -84, -78, -72, -69, -66, -63,
        -60, -57, -54, -51, -48, -45, -42, -39, -36, -33, -32, -31, -30, -29, -28, -27, -26, -25};

    headphone_amp_control uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .left_amp_en(left_amp_en), .right_amp_en(right_amp_en),
        .charge_pump_en(charge_pump_en), .bias_ref_en(bias_ref_en), .mono_sum_en(mono_sum_en),
        .left_mute(left_mute), .right_mute(right_mute), .gain_half_db(gain_half_db));
    apb_host_model host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    // ------------------------------------------------------------
    // behavioural model, status layout
    // ------------------------------------------------------------
    function automatic logic [16:0] expect_status(int m, int v);
        logic [16:0] s;
        logic pd, lon, ron;
        int c, g;
        c = v & 63;
        g = (c < 31) ? lo_tab[c] : c - 55;
        pd = v[6];
        lon = !pd && !m[4] && !m[6];
        ron = !pd && !m[4] && !m[1];
        s = {g[8:0], 1'b0, 1'(m[0]), 1'(m[2]), lon && m[1], !pd && m[5], !pd, ron, lon};
        return s;
    endfunction

    task automatic stop_test();
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check_all();
        logic [16:0] s;
        s = expect_status(mode_m, vol_m);
        @(negedge pclk);
        `chk("left_amp_en", s[0], left_amp_en)
        `chk("right_amp_en", s[1], right_amp_en)
        `chk("charge_pump_en", s[2], charge_pump_en)
        `chk("bias_ref_en", s[3], bias_ref_en)
        `chk("mono_sum_en", s[4], mono_sum_en)
        `chk("left_mute", s[5], left_mute)
        `chk("right_mute", s[6], right_mute)
        `chk("gain_half_db", s[16:8], gain_half_db)
        @(posedge pclk);
        host.xfer(1'b0, status_reg_addr, 32'h0, rd, err);
        `chk("status", {15'h0, s}, rd)
        host.xfer(1'b0, mode_reg_addr, 32'h0, rd, err);
        `chk("mode", 32'(mode_m), rd)
        host.xfer(1'b0, volume_reg_addr, 32'h0, rd, err);
        `chk("volume", 32'(vol_m), rd)
    endtask

    task automatic put(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, err);
        `chk("write_err", 1'b0, err)
        if (a == mode_reg_addr)
            mode_m = int'(d & 32'h77);
        else
            vol_m = int'(d & 32'h7f);
        check_all();
    endtask

    // ------------------------------------------------------------
    // clock, timeout, sequence
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            err_total++;
            stop_test();
        end
    end

    initial
    begin
        presetn = 1'b0;
        mode_m = 0;
        vol_m = 0;
        repeat (5) @(posedge pclk);
        `chk("gain_reset", 9'h140, gain_half_db)
        presetn <= 1'b1;
        @(posedge pclk);
        check_all();
        for (int c = 0; c < 64; c++)
            put(volume_reg_addr, 32'(c));
        for (int k = 0; k < 16; k++)
        begin
            put(volume_reg_addr, 32'((k[3] << 6) | ($random(seed) & 63)));
            put(mode_reg_addr, 32'((k[2] << 4) | (k[1] << 6) | k[0] << 1 | ($random(seed) & 37)));
        end
        put(mode_reg_addr, 32'h20);
        put(mode_reg_addr, 32'h00);
        for (int k = 0; k < 30; k++)
        begin
            put(mode_reg_addr, 32'($random(seed)));
            put(volume_reg_addr, 32'($random(seed)));
        end
        host.xfer(1'b1, status_reg_addr, 32'hffff_ffff, rd, err);
        `chk("status_write_err", 1'b1, err)
        host.xfer(1'b0, 12'h00c, 32'h0, rd, err);
        `chk("unmapped_read_err", 1'b1, err)
        `chk("unmapped_read_data", 32'h0, rd)
        host.xfer(1'b1, 12'h010, 32'hffff_ffff, rd, err);
        `chk("unmapped_write_err", 1'b1, err)
        check_all();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `chk("pump_reset", 1'b0, charge_pump_en)
        presetn <= 1'b1;
        mode_m = 0;
        vol_m = 0;
        @(posedge pclk);
        check_all();
        stop_test();
    end
endmodule
`default_nettype wire
